// ===== core/pcl_pkg.sv
// Package: constants and types for the program counter load logic
package pcl_pkg;
    localparam int PC_W = 15;
    localparam int LO_W = 8;
    localparam int HI_W = 7;
    localparam int CALL_HI_W = 3;
    localparam int SP_W = 5;
    localparam int STK_DEPTH = 16;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_STATUS_FLAG_SHADOW = 12'hfe4;
    localparam logic [ADDR_W-1:0] OFF_ACC_SHAD = 12'hfe5;
    localparam logic [ADDR_W-1:0] OFF_BANK_SHAD = 12'hfe6;
    localparam logic [ADDR_W-1:0] OFF_LATCH_SHAD = 12'hfe7;
    localparam logic [ADDR_W-1:0] OFF_P0L_SHAD = 12'hfe8;
    localparam logic [ADDR_W-1:0] OFF_P0H_SHAD = 12'hfe9;
    localparam logic [ADDR_W-1:0] OFF_P1L_SHAD = 12'hfea;
    localparam logic [ADDR_W-1:0] OFF_P1H_SHAD = 12'hfeb;
    localparam logic [ADDR_W-1:0] OFF_STACK_PTR = 12'hfed;
    localparam logic [ADDR_W-1:0] OFF_STACK_TOP_LO = 12'hfee;
    localparam logic [ADDR_W-1:0] OFF_STACK_TOP_HI = 12'hfef;
    // Registers of our own for the counter low byte and high latch
    localparam logic [ADDR_W-1:0] OFF_COUNTER_LO = 12'hff0;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_LATCH = 12'hff1;
    localparam logic [SP_W-1:0] SP_RST = 5'h1f;
    localparam logic [7:0] STATUS_MASK = 8'h07;
    localparam logic [7:0] BANK_MASK = 8'h1f;
    localparam logic [7:0] HI7_MASK = 8'h7f;

    typedef enum logic [2:0] {
        PCL_OP_NONE,
        PCL_OP_STEP,
        PCL_OP_ADD_LOW,
        PCL_OP_CALL,
        PCL_OP_ACCUMULATOR_BASED_CALL,
        PCL_OP_INTR,
        PCL_OP_RETURN,
        PCL_OP_RETURN_FROM_INTERRUPT
    } pcl_op_e;

    // Core request: one operation per cycle
    typedef struct packed {
        pcl_op_e op;
        logic [10:0] operand;
        logic [7:0] addend;
        logic [PC_W-1:0] intr_vector;
    } pcl_req_s;

    // Live context registers owned by the core
    typedef struct packed {
        logic [2:0] status;
        logic [7:0] acc;
        logic [4:0] bank;
        logic [6:0] latch;
        logic [7:0] p0l;
        logic [7:0] p0h;
        logic [7:0] p1l;
        logic [7:0] p1h;
    } pcl_ctx_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [7:0] writedata;
    } pcl_bus_req_s;

    typedef struct packed {
        logic waitrequest;
        logic readdatavalid;
        logic [7:0] readdata;
    } pcl_bus_rsp_s;
endpackage

// ===== core/pcl_stack_mem.sv
// Hardware return stack storage with registered read data
`timescale 1ns/1ps
module pcl_stack_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15
) (
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents survive all resets
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ===== core/pcl_shadow_bank.sv
// Shadow copies of the context registers, unreset so they survive resets
`timescale 1ns/1ps
module pcl_shadow_bank
    import pcl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic save_i,
    input wire logic wr_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire pcl_pkg::pcl_ctx_s live_i,
    output pcl_pkg::pcl_ctx_s shadow_o
);
    pcl_ctx_s state_reg;
    pcl_ctx_s state_next;

    always_comb begin
        state_next = state_reg;
        if (save_i) begin
            state_next = live_i;
        end else if (wr_i) begin
            unique case (wr_addr_i)
                OFF_STATUS_FLAG_SHADOW: state_next.status = wr_data_i[2:0];
                OFF_ACC_SHAD: state_next.acc = wr_data_i;
                OFF_BANK_SHAD: state_next.bank = wr_data_i[4:0];
                OFF_LATCH_SHAD: state_next.latch = wr_data_i[6:0];
                OFF_P0L_SHAD: state_next.p0l = wr_data_i;
                OFF_P0H_SHAD: state_next.p0h = wr_data_i;
                OFF_P1L_SHAD: state_next.p1l = wr_data_i;
                OFF_P1H_SHAD: state_next.p1h = wr_data_i;
                default: state_next = state_reg;
            endcase
        end
    end

    // No reset term: unknown at power-on, unchanged by resets
    always_ff @(posedge clk_sys_i) begin
        state_reg <= state_next;
    end

    assign shadow_o = state_reg;
endmodule

// ===== core/pcl_pc_ctrl.sv
// Program counter sequencing, stack access and shadow registers
`timescale 1ns/1ps
module pcl_pc_ctrl
    import pcl_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire pcl_pkg::pcl_req_s req_i,
    input wire pcl_pkg::pcl_ctx_s ctx_i,
    input wire pcl_pkg::pcl_bus_req_s bus_i,
    output pcl_pkg::pcl_bus_rsp_s bus_o,
    output logic [PC_W-1:0] pc_o,
    output logic [HI_W-1:0] latch_o,
    output logic restore_o,
    output pcl_pkg::pcl_ctx_s restore_ctx_o
);
    import pcl_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [HI_W-1:0] latch;
        logic [SP_W-1:0] sp;
        logic rd_pend;
        logic waitreq;
        logic [ADDR_W-1:0] rd_addr;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic restore;
        logic [IDX_W-1:0] ret_idx;
    } pcl_state_s;

    pcl_state_s state_reg;
    pcl_state_s state_next;

    pcl_ctx_s shadow;
    logic [PC_W-1:0] stk_rd;
    logic stk_we;
    logic [IDX_W-1:0] stk_waddr;
    logic [PC_W-1:0] stk_wdata;
    logic [IDX_W-1:0] stk_raddr;
    logic sh_wr;
    logic sh_save;
    logic [PC_W-1:0] pc_inc;
    logic [SP_W-1:0] sp_inc;
    logic [SP_W-1:0] sp_dec;
    logic push;
    logic pop;
    logic bus_wr;
    logic [7:0] rd_val;

    assign pc_inc = state_reg.pc + PC_W'(1);
    assign sp_inc = state_reg.sp + SP_W'(1);
    assign sp_dec = state_reg.sp - SP_W'(1);
    assign push = (req_i.op == PCL_OP_CALL) || (req_i.op == PCL_OP_ACCUMULATOR_BASED_CALL)
        || (req_i.op == PCL_OP_INTR);
    assign pop = (req_i.op == PCL_OP_RETURN) || (req_i.op == PCL_OP_RETURN_FROM_INTERRUPT);
    // A write lands only at the edge where the master sees waitrequest low
    assign bus_wr = bus_i.write && !state_reg.waitreq;

    // Registered stack read at the next pointer keeps the top entry in step with the pointer
    assign stk_raddr = state_next.sp[IDX_W-1:0];

    pcl_stack_mem #(
        .DEPTH(DEPTH),
        .WIDTH(PC_W)
    ) u_stack (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(stk_we),
        .wr_addr_i(stk_waddr),
        .wr_data_i(stk_wdata),
        .rd_addr_i(stk_raddr),
        .rd_data_o(stk_rd)
    );

    // Shadows must survive every reset, so nothing may load them while it is held
    assign sh_wr = bus_wr && nrst_i && (bus_i.address >= OFF_STATUS_FLAG_SHADOW)
        && (bus_i.address <= OFF_P1H_SHAD);
    assign sh_save = nrst_i && (req_i.op == PCL_OP_INTR);

    pcl_shadow_bank u_shadow (
        .clk_sys_i(clk_sys_i),
        .save_i(sh_save),
        .wr_i(sh_wr),
        .wr_addr_i(bus_i.address),
        .wr_data_i(bus_i.writedata),
        .live_i(ctx_i),
        .shadow_o(shadow)
    );

    // Read mux; unmapped addresses and unused bits return zero
    always_comb begin
        rd_val = 8'h00;
        unique case (state_reg.rd_addr)
            OFF_STATUS_FLAG_SHADOW: rd_val = {5'h00, shadow.status};
            OFF_ACC_SHAD: rd_val = shadow.acc;
            OFF_BANK_SHAD: rd_val = {3'h0, shadow.bank};
            OFF_LATCH_SHAD: rd_val = {1'b0, shadow.latch};
            OFF_P0L_SHAD: rd_val = shadow.p0l;
            OFF_P0H_SHAD: rd_val = shadow.p0h;
            OFF_P1L_SHAD: rd_val = shadow.p1l;
            OFF_P1H_SHAD: rd_val = shadow.p1h;
            OFF_STACK_PTR: rd_val = {3'h0, state_reg.sp};
            OFF_STACK_TOP_LO: rd_val = stk_rd[LO_W-1:0];
            OFF_STACK_TOP_HI: rd_val = {1'b0, stk_rd[PC_W-1:LO_W]};
            OFF_COUNTER_LO: rd_val = state_reg.pc[LO_W-1:0];
            OFF_COUNTER_LATCH: rd_val = {1'b0, state_reg.latch};
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        stk_we = 1'b0;
        stk_waddr = state_reg.sp[IDX_W-1:0];
        stk_wdata = state_reg.pc;
        state_next.restore = 1'b0;
        state_next.rsp_valid = 1'b0;
        state_next.rsp_data = 8'h00;

        // Instruction sequencing
        unique case (req_i.op)
            PCL_OP_NONE: state_next.pc = state_reg.pc;
            PCL_OP_STEP: state_next.pc = pc_inc;
            PCL_OP_ADD_LOW: begin
                state_next.pc[LO_W-1:0] = state_reg.pc[LO_W-1:0] + req_i.addend;
                state_next.pc[PC_W-1:LO_W] = state_reg.latch;
            end
            PCL_OP_CALL: state_next.pc = {state_reg.latch[HI_W-1:CALL_HI_W],
                req_i.operand};
            PCL_OP_ACCUMULATOR_BASED_CALL: state_next.pc = {state_reg.latch, ctx_i.acc};
            PCL_OP_INTR: state_next.pc = req_i.intr_vector;
            PCL_OP_RETURN, PCL_OP_RETURN_FROM_INTERRUPT: state_next.pc = stk_rd;
        endcase

        // Push: pointer up then store return address; latch untouched
        if (push) begin
            state_next.sp = sp_inc;
            stk_we = 1'b1;
            stk_waddr = sp_inc[IDX_W-1:0];
            stk_wdata = (req_i.op == PCL_OP_INTR) ? state_reg.pc : pc_inc;
        end else if (pop) begin
            state_next.sp = sp_dec;
        end
        state_next.restore = (req_i.op == PCL_OP_RETURN_FROM_INTERRUPT);

        // Avalon-MM slave: one wait cycle per write, two per read
        if (bus_i.read && !state_reg.rd_pend && !state_reg.rsp_valid) begin
            state_next.rd_pend = 1'b1;
            state_next.rd_addr = bus_i.address;
        end else if (state_reg.rd_pend) begin
            state_next.rd_pend = 1'b0;
            state_next.rsp_valid = 1'b1;
            state_next.rsp_data = rd_val;
        end
        // Registered waitrequest: low only in the cycle that completes an access
        state_next.waitreq = !(bus_i.write && state_reg.waitreq) && !state_reg.rd_pend;
        if (bus_wr && !push && !pop) begin
            unique case (bus_i.address)
                OFF_COUNTER_LO: state_next.pc = {state_reg.latch, bus_i.writedata};
                OFF_COUNTER_LATCH: state_next.latch = bus_i.writedata[HI_W-1:0];
                OFF_STACK_PTR: state_next.sp = bus_i.writedata[SP_W-1:0];
                OFF_STACK_TOP_LO: begin
                    stk_we = 1'b1;
                    stk_wdata = {stk_rd[PC_W-1:LO_W], bus_i.writedata};
                end
                OFF_STACK_TOP_HI: begin
                    stk_we = 1'b1;
                    stk_wdata = {bus_i.writedata[HI_W-1:0], stk_rd[LO_W-1:0]};
                end
                default: state_next.latch = state_reg.latch;
            endcase
        end

        if (!nrst_i) begin
            state_next.pc = '0;
            state_next.latch = '0;
            state_next.sp = SP_RST;
            state_next.rd_pend = 1'b0;
            state_next.waitreq = 1'b1;
            state_next.rsp_valid = 1'b0;
            state_next.rsp_data = 8'h00;
            state_next.restore = 1'b0;
            state_next.rd_addr = '0;
            stk_we = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        state_reg <= state_next;
    end

    assign pc_o = state_reg.pc;
    assign latch_o = state_reg.latch;
    assign restore_o = state_reg.restore;
    assign restore_ctx_o = shadow;
    assign bus_o.waitrequest = state_reg.waitreq;
    assign bus_o.readdatavalid = state_reg.rsp_valid;
    assign bus_o.readdata = state_reg.rsp_data;

    AST_RESET_CLEARS_PC: assert property (@(posedge clk_sys_i)
        !nrst_i |=> pc_o == '0)
        else $error("PC not cleared by reset");
    AST_LOW_WRITE_LOADS_LATCH: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        bus_wr && bus_i.address == OFF_COUNTER_LO && !push && !pop
        |=> pc_o == {$past(latch_o), $past(bus_i.writedata)})
        else $error("Low byte write did not load latch");
    AST_ADD_LOW_NO_CARRY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_i.op == PCL_OP_ADD_LOW && !bus_wr
        |=> pc_o[PC_W-1:LO_W] == $past(latch_o))
        else $error("Computed jump changed high bits wrongly");
    AST_CALL_TARGET: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_i.op == PCL_OP_CALL
        |=> pc_o[PC_W-1:LO_W+CALL_HI_W] == $past(latch_o[HI_W-1:CALL_HI_W])
        && pc_o[LO_W+CALL_HI_W-1:0] == $past(req_i.operand))
        else $error("Call target wrong");
    AST_ACCUMULATOR_BASED_CALL_TARGET: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_i.op == PCL_OP_ACCUMULATOR_BASED_CALL |=> pc_o == {$past(latch_o), $past(ctx_i.acc)})
        else $error("Accumulator call target wrong");
    AST_PUSH_POINTER: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        push |=> state_reg.sp == $past(state_reg.sp) + SP_W'(1))
        else $error("Push did not advance pointer");
    AST_PUSH_KEEPS_LATCH: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (push || pop) |=> $stable(latch_o))
        else $error("Stack access changed latch");
    AST_READ_ANSWER: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        bus_i.read && !state_reg.rd_pend && !state_reg.rsp_valid
        ##0 bus_i.address == OFF_COUNTER_LATCH |=> ##1 bus_o.readdata[7] == 1'b0)
        else $error("Unimplemented bit read nonzero");
    AST_RETURN_FROM_INTERRUPT_RESTORE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_i.op == PCL_OP_RETURN_FROM_INTERRUPT |=> restore_o)
        else $error("Return from interrupt gave no restore");
    AST_STEP_INCREMENTS: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        req_i.op == PCL_OP_STEP && !bus_wr |=> pc_o == $past(pc_o) + PC_W'(1))
        else $error("Step did not advance the counter");
    AST_LATCH_ONLY_BY_BUS: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        !(bus_wr && bus_i.address == OFF_COUNTER_LATCH) |=> $stable(latch_o))
        else $error("Counter high latch changed without a write");
    AST_INTR_VECTOR: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        req_i.op == PCL_OP_INTR |=> pc_o == $past(req_i.intr_vector))
        else $error("Interrupt entry did not load the vector");
    AST_SHADOW_SAVE: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        req_i.op == PCL_OP_INTR |=> restore_ctx_o == $past(ctx_i))
        else $error("Interrupt entry did not save the context");

    // Stack pointer and stack storage
    AST_POP_POINTER: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        pop |=> state_reg.sp == $past(state_reg.sp) - SP_W'(1))
        else $error("Pop did not lower pointer");
    AST_PUSH_STORES: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        push |-> stk_we && stk_waddr == sp_inc[IDX_W-1:0])
        else $error("Push did not store at the raised pointer");
    AST_CALL_PUSHES_NEXT: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        (req_i.op == PCL_OP_CALL || req_i.op == PCL_OP_ACCUMULATOR_BASED_CALL) |-> stk_wdata == pc_inc)
        else $error("Call stored the wrong return address");
    AST_POP_LOADS_TOP: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        pop |=> pc_o == $past(stk_rd))
        else $error("Return did not load the stack top");
    AST_RESET_SPARES_STORES: assert property (@(posedge clk_sys_i)
        !nrst_i |-> !stk_we && !sh_wr && !sh_save)
        else $error("Stack or shadow loaded during reset");
    AST_RESET_POINTER: assert property (@(posedge clk_sys_i)
        !nrst_i |=> state_reg.sp == SP_RST && latch_o == '0)
        else $error("Reset left pointer or latch set");

    // Read data masks and register bus handshake
    AST_LOW_READ_MATCHES: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        state_reg.rd_pend && state_reg.rd_addr == OFF_COUNTER_LO
        |=> bus_o.readdata == $past(pc_o[LO_W-1:0]))
        else $error("Counter low byte read wrong");
    AST_TOP_HIGH_BIT_ZERO: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        state_reg.rd_pend && state_reg.rd_addr == OFF_STACK_TOP_HI
        |=> (bus_o.readdata & ~HI7_MASK) == 8'h00)
        else $error("Stack top high read showed bit 7");
    AST_STATUS_UPPER_ZERO: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        state_reg.rd_pend && state_reg.rd_addr == OFF_STATUS_FLAG_SHADOW
        |=> (bus_o.readdata & ~STATUS_MASK) == 8'h00)
        else $error("Status shadow read showed upper bits");
    AST_BANK_UPPER_ZERO: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        state_reg.rd_pend && state_reg.rd_addr == OFF_BANK_SHAD
        |=> (bus_o.readdata & ~BANK_MASK) == 8'h00)
        else $error("Bank shadow read showed upper bits");
    AST_UNMAPPED_READS_ZERO: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        state_reg.rd_pend && !(state_reg.rd_addr inside {[OFF_STATUS_FLAG_SHADOW:OFF_P1H_SHAD],
            [OFF_STACK_PTR:OFF_COUNTER_LATCH]}) |=> bus_o.readdata == 8'h00)
        else $error("Unmapped address read nonzero");
    AST_WRITE_ONE_WAIT: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        bus_i.write && bus_o.waitrequest |=> !bus_o.waitrequest)
        else $error("Write not answered after one wait cycle");
    AST_READ_TWO_WAITS: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        bus_i.read && !state_reg.rd_pend && !state_reg.rsp_valid
        |=> bus_o.waitrequest ##1 !bus_o.waitrequest && bus_o.readdatavalid)
        else $error("Read not answered after two wait cycles");
    AST_VALID_ONE_CYCLE: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        bus_o.readdatavalid |=> !bus_o.readdatavalid)
        else $error("Read data valid stood too long");

    COV_CALL: cover property (@(posedge clk_sys_i) req_i.op == PCL_OP_CALL);
    COV_ACCUMULATOR_BASED_CALL_RET: cover property (@(posedge clk_sys_i)
        req_i.op == PCL_OP_ACCUMULATOR_BASED_CALL ##[1:40] req_i.op == PCL_OP_RETURN);
    COV_INTR_RETURN_FROM_INTERRUPT: cover property (@(posedge clk_sys_i)
        req_i.op == PCL_OP_INTR ##[1:100] req_i.op == PCL_OP_RETURN_FROM_INTERRUPT);
    COV_LOW_WRITE: cover property (@(posedge clk_sys_i)
        bus_wr && bus_i.address == OFF_COUNTER_LO);
    COV_TOP_WRITE: cover property (@(posedge clk_sys_i)
        bus_wr && bus_i.address == OFF_STACK_TOP_HI);
endmodule

// ===== sim/pcl_pc_ctrl_bench.sv
// Self-checking testbench for the program counter load logic
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module pcl_pc_ctrl_bench;
    import pcl_pkg::*;
    logic clk_sys_i;
    logic nrst_i;
    pcl_req_s req;
    pcl_ctx_s ctx;
    pcl_bus_req_s bus;
    pcl_bus_rsp_s rsp;
    logic [PC_W-1:0] pc;
    logic [HI_W-1:0] latch;
    logic restore;
    pcl_ctx_s rctx;
    int mismatches = 0;
    int cmp_count = 0;
    logic [7:0] rd;

    pcl_pc_ctrl uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req), .ctx_i(ctx),
        .bus_i(bus), .bus_o(rsp), .pc_o(pc), .latch_o(latch), .restore_o(restore),
        .restore_ctx_o(rctx));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low; a stuck slave counts as a mismatch
    task automatic bus_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        bus <= '{read: ~wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 20);
        rd = rsp.readdata;
        if (n >= 20) mismatches++;
        if (!wr) `CHECK(rsp.readdatavalid, 1'b1)
        bus <= '{read: 1'b0, write: 1'b0, address: a, writedata: d};
        #1;
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus_xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        bus_xfer(1'b0, a, 8'h00);
        `CHECK(rd, exp)
    endtask

    // One instruction for one cycle; the counter has moved when this returns
    task automatic do_op(input pcl_op_e op, input logic [10:0] opr, input logic [7:0] add);
        @(posedge clk_sys_i);
        req <= '{op: op, operand: opr, addend: add, intr_vector: 15'h1234};
        @(posedge clk_sys_i);
        req.op <= PCL_OP_NONE;
        #1;
    endtask

    task automatic t_reset();
        `CHECK(pc, 15'h0000)
        `CHECK(latch, 7'h00)
        rd_chk(OFF_STACK_PTR, 8'h1f);
        rd_chk(OFF_COUNTER_LO, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_load();
        wr_reg(OFF_COUNTER_LATCH, 8'hda);
        `CHECK(latch, 7'h5a)
        `CHECK(pc, 15'h0000)
        rd_chk(OFF_COUNTER_LATCH, 8'h5a);
        wr_reg(OFF_COUNTER_LO, 8'hf0);
        `CHECK(pc, 15'h5af0)
        rd_chk(OFF_COUNTER_LO, 8'hf0);
        // Offset wraps inside the 256-byte block, high part untouched
        do_op(PCL_OP_ADD_LOW, 11'h000, 8'h20);
        `CHECK(pc, 15'h5a10)
        do_op(PCL_OP_STEP, 11'h000, 8'h00);
        `CHECK(pc, 15'h5a11)
        $display("test load done");
    endtask

    task automatic t_call();
        do_op(PCL_OP_CALL, 11'h6a5, 8'h00);
        `CHECK(pc, 15'h5ea5)
        `CHECK(latch, 7'h5a)
        rd_chk(OFF_STACK_PTR, 8'h00);
        rd_chk(OFF_STACK_TOP_LO, 8'h12);
        rd_chk(OFF_STACK_TOP_HI, 8'h5a);
        do_op(PCL_OP_RETURN, 11'h000, 8'h00);
        `CHECK(pc, 15'h5a12)
        rd_chk(OFF_STACK_PTR, 8'h1f);
        do_op(PCL_OP_ACCUMULATOR_BASED_CALL, 11'h000, 8'h00);
        `CHECK(pc, 15'h5a77)
        wr_reg(OFF_STACK_TOP_HI, 8'hff);
        rd_chk(OFF_STACK_TOP_HI, 8'h7f);
        rd_chk(OFF_STACK_TOP_LO, 8'h13);
        do_op(PCL_OP_RETURN, 11'h000, 8'h00);
        `CHECK(pc, 15'h7f13)
        `CHECK(latch, 7'h5a)
        $display("test call done");
    endtask

    task automatic t_intr();
        logic [7:0] sh_exp [8];
        logic [PC_W-1:0] saved;
        pcl_ctx_s cap;
        int n;
        sh_exp = '{8'h05, 8'h77, 8'h1b, 8'h5a, 8'h81, 8'h82, 8'h83, 8'h84};
        saved = pc;
        n = 0;
        do_op(PCL_OP_INTR, 11'h000, 8'h00);
        `CHECK(pc, 15'h1234)
        for (int i = 0; i < 8; i++) begin
            rd_chk(OFF_STATUS_FLAG_SHADOW + 12'(i), sh_exp[i]);
        end
        wr_reg(OFF_STATUS_FLAG_SHADOW, 8'hfa);
        rd_chk(OFF_STATUS_FLAG_SHADOW, 8'h02);
        // Live values change so a restore must come from the shadows
        @(posedge clk_sys_i);
        ctx.acc <= 8'h00;
        ctx.status <= 3'h0;
        do_op(PCL_OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00);
        `CHECK(pc, saved)
        for (int k = 0; k < 3; k++) begin
            if (restore === 1'b1) begin
                n++;
                cap = rctx;
            end
            @(posedge clk_sys_i);
            #1;
        end
        `CHECK(n, 1)
        `CHECK(cap.status, 3'h2)
        `CHECK(cap.acc, 8'h77)
        `CHECK(cap.bank, 5'h1b)
        `CHECK(cap.p1h, 8'h84)
        $display("test interrupt done");
    endtask

    task automatic t_unmapped();
        wr_reg(12'hfec, 8'ha5);
        rd_chk(12'hfec, 8'h00);
        rd_chk(12'h000, 8'h00);
        $display("test unmapped done");
    endtask

    task automatic t_rereset();
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        #1;
        `CHECK(pc, 15'h0000)
        `CHECK(latch, 7'h00)
        rd_chk(OFF_STACK_PTR, 8'h1f);
        rd_chk(OFF_ACC_SHAD, 8'h77);
        rd_chk(OFF_STATUS_FLAG_SHADOW, 8'h02);
        $display("test second reset done");
    endtask

    initial begin
        nrst_i = 1'b0;
        req = '0;
        bus = '0;
        ctx = '{status: 3'h5, acc: 8'h77, bank: 5'h1b, latch: 7'h5a,
            p0l: 8'h81, p0h: 8'h82, p1l: 8'h83, p1h: 8'h84};
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        #1;
        t_reset();
        t_load();
        t_call();
        t_intr();
        t_unmapped();
        t_rereset();
        stop_test();
    end

    // The whole run takes about 150 cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        mismatches++;
        stop_test();
    end
endmodule
